// ===== bench/fcs_unit_properties.sv
// concurrent checks on the ports of the floating-point compatibility unit
// assumes fcs_pkg is compiled first; bound into every fcs_unit instance
`timescale 1ns/1ns
module fcs_unit_properties (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // issue and modes
    input fcs_pkg::fcs_req_type req,
    input wire logic reqReady,
    input wire logic [1:0] roundMode,
    input wire logic legacyWaitMode,
    // memory port
    input fcs_pkg::fcs_wr_type memWr,
    input wire logic memWrFault,
    // results
    input wire logic [31:0] stackTop,
    input wire logic [31:0] stackSecond,
    input wire logic [3:0] condCodes,
    input fcs_pkg::fcs_exc_type excFlags,
    input wire logic errReport,
    input wire logic opDone,
    input wire logic storeFault,
    input wire logic [31:0] savedPtr,
    input wire logic savedPtrValid
);
    import fcs_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic taken;
    assign taken = req.valid && reqReady;

    property p_xtr_zero;
        taken && req.op == FCS_OP_EXPONENT_EXTRACT && req.operand[30:0] == 31'h0
            |=> opDone && stackSecond == 32'hFF800000 && excFlags.divZero;
    endproperty
    a_xtr_zero: assert property (p_xtr_zero)
        else $error("extract of zero wrong");
    property p_xtr_inf;
        taken && req.op == FCS_OP_EXPONENT_EXTRACT && req.operand == 32'h7F800000
            |=> stackSecond == 32'h7F800000 && excFlags == 3'h0;
    endproperty
    a_xtr_inf: assert property (p_xtr_inf)
        else $error("extract of infinity wrong");
    property p_const_up;
        taken && req.op == FCS_OP_LOAD_LOG2_TEN && roundMode == 2'h2
            |=> !reqReady ##1 opDone && stackTop == 32'h40549A79;
    endproperty
    a_const_up: assert property (p_const_up)
        else $error("rounded constant wrong");
    property p_legacy_nop;
        taken && req.op inside {FCS_OP_LEGACY_PMODE_ANNOUNCE, FCS_OP_LEGACY_INT_ENABLE,
            FCS_OP_LEGACY_INT_DISABLE} |=> opDone && !errReport && $stable(stackTop)
            && $stable(stackSecond) && $stable(excFlags) && $stable(condCodes);
    endproperty
    a_legacy_nop: assert property (p_legacy_nop)
        else $error("legacy op changed state");
    property p_empty_codes;
        condCodes != 4'hD && condCodes != 4'hF;
    endproperty
    a_empty_codes: assert property (p_empty_codes)
        else $error("forbidden condition codes");
    property p_wait_legacy;
        taken && req.op == FCS_OP_WAIT_PREFIX && legacyWaitMode |=> !errReport;
    endproperty
    a_wait_legacy: assert property (p_wait_legacy)
        else $error("legacy wait reported error");
    property p_store_fault;
        taken && req.op == FCS_OP_STORE ##1 memWr.wrEn && memWrFault
            |=> storeFault && opDone && !memWr.wrEn;
    endproperty
    a_store_fault: assert property (p_store_fault)
        else $error("faulted store wrote high half");
    property p_store_hi;
        taken && req.op == FCS_OP_STORE ##1 memWr.wrEn && !memWrFault
            |=> memWr.wrEn && memWr.wrAddr == $past(memWr.wrAddr) + 32'h2;
    endproperty
    a_store_hi: assert property (p_store_hi)
        else $error("high half not written");
    property p_done_cause;
        opDone |-> $past(taken) || $past(taken, 2);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("done without request");
    property p_refuse;
        !reqReady |=> opDone;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("busy without completion");
endmodule

bind fcs_unit fcs_unit_properties chk (.clk_sys(clk_sys), .rst(rst), .req(req),
    .reqReady(reqReady), .roundMode(roundMode), .legacyWaitMode(legacyWaitMode),
    .memWr(memWr), .memWrFault(memWrFault), .stackTop(stackTop),
    .stackSecond(stackSecond), .condCodes(condCodes), .excFlags(excFlags),
    .errReport(errReport), .opDone(opDone), .storeFault(storeFault),
    .savedPtr(savedPtr), .savedPtrValid(savedPtrValid));

// ===== bench/fcs_unit_tb.sv
// self-checking bench for the floating-point compatibility unit
// assumes fcs_pkg and the checker are compiled first; one request at a time
`timescale 1ns/1ns
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module fcs_unit_tb;
    import fcs_pkg::*;
    logic clk_sys;
    logic rst;
    fcs_req_type req;
    logic reqReady;
    logic [1:0] roundMode;
    logic legacyWaitMode;
    fcs_wr_type memWr;
    logic memWrFault;
    logic [31:0] stackTop;
    logic [31:0] stackSecond;
    logic [3:0] condCodes;
    fcs_exc_type excFlags;
    logic errReport;
    logic opDone;
    logic storeFault;
    logic [31:0] savedPtr;
    logic savedPtrValid;
    int mismatches;
    int num_checks;
    int cycles;
    int lat;
    logic err;
    logic sf;
    logic pv;
    logic [31:0] wrLog [$];
    logic [15:0] datLog [$];
    logic [31:0] piTab [4] = '{32'h40490FDB, 32'h40490FDA, 32'h40490FDB, 32'h40490FDA};
    logic [31:0] l2tTab [4] = '{32'h40549A78, 32'h40549A78, 32'h40549A79, 32'h40549A78};
    fcs_op_type lgOps [4] = '{FCS_OP_LEGACY_PMODE_ANNOUNCE, FCS_OP_LEGACY_INT_ENABLE,
        FCS_OP_LEGACY_INT_DISABLE, FCS_OP_NOP};

    fcs_unit uut (.clk_sys(clk_sys), .rst(rst), .req(req), .reqReady(reqReady),
        .roundMode(roundMode), .legacyWaitMode(legacyWaitMode), .memWr(memWr),
        .memWrFault(memWrFault), .stackTop(stackTop), .stackSecond(stackSecond),
        .condCodes(condCodes), .excFlags(excFlags), .errReport(errReport),
        .opDone(opDone), .storeFault(storeFault), .savedPtr(savedPtr),
        .savedPtrValid(savedPtrValid));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // writes are logged mid-cycle, where the registered port has settled
    always @(negedge clk_sys) begin
        if (memWr.wrEn === 1'b1) begin
            wrLog.push_back(memWr.wrAddr);
            datLog.push_back(memWr.wrData);
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one request, then wait a bounded time for its completion pulse
    task automatic issue(input fcs_op_type op, input logic [31:0] opd, input logic mr,
        input logic [31:0] a);
        int i;
        @(posedge clk_sys);
        req <= '{valid: 1'b1, op: op, operand: opd, memRef: mr, memAddr: a};
        @(posedge clk_sys);
        req.valid <= 1'b0;
        lat = 9;
        err = 1'b0;
        sf = 1'b0;
        pv = 1'b0;
        for (i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            if (opDone === 1'b1) begin
                lat = i + 1;
                err = errReport;
                sf = storeFault;
                pv = savedPtrValid;
                break;
            end
        end
        // let the write logger of this same edge finish first
        #1;
    endtask

    task automatic t_examine();
        issue(FCS_OP_EXAMINE_CLASS, 32'h0, 1'b0, 32'h0);
        `CHK(condCodes, 4'h9, "empty examine codes")
        `CHK(lat, 1, "examine latency")
    endtask

    task automatic t_extract();
        issue(FCS_OP_EXPONENT_EXTRACT, 32'h0, 1'b0, 32'h0);
        `CHK(stackSecond, 32'hFF800000, "zero extract second")
        `CHK(stackTop, 32'h0, "zero extract top")
        `CHK(excFlags.divZero, 1'b1, "zero extract flag")
        issue(FCS_OP_EXPONENT_EXTRACT, 32'h7F800000, 1'b0, 32'h0);
        `CHK(stackSecond, 32'h7F800000, "inf extract second")
        `CHK(excFlags, 3'h0, "inf extract flags")
        `CHK(err, 1'b1, "earlier error reported")
        issue(FCS_OP_EXPONENT_EXTRACT, 32'h40400000, 1'b0, 32'h0);
        `CHK(stackSecond, 32'h3F800000, "finite exponent")
        `CHK(stackTop, 32'h3FC00000, "finite significand")
    endtask

    task automatic t_const();
        logic [31:0] prev;
        logic [31:0] expv;
        int m;
        int k;
        prev = 32'h3FC00000;
        for (m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            roundMode <= m[1:0];
            for (k = 0; k < 2; k++) begin
                issue(k == 1 ? FCS_OP_LOAD_LOG2_TEN : FCS_OP_LOAD_PI, 32'h0, 1'b0, 32'h0);
                expv = (k == 1) ? l2tTab[m] : piTab[m];
                `CHK(stackTop, expv, "rounded constant")
                `CHK(stackSecond, prev, "constant push")
                `CHK(lat, 2, "constant latency")
                prev = expv;
            end
        end
    endtask

    task automatic t_legacy_wait();
        logic [31:0] t0;
        logic [31:0] s0;
        int i;
        t0 = stackTop;
        s0 = stackSecond;
        for (i = 0; i < 4; i++) begin
            issue(lgOps[i], 32'h0, 1'b0, 32'h0);
            `CHK(stackTop, t0, "legacy top")
            `CHK(stackSecond, s0, "legacy second")
            `CHK(err, 1'b0, "legacy reported")
        end
        // pending precision from the constant loads is still held here
        @(posedge clk_sys);
        legacyWaitMode <= 1'b1;
        issue(FCS_OP_WAIT_PREFIX, 32'h0, 1'b0, 32'h0);
        `CHK(err, 1'b0, "legacy wait reported")
        issue(FCS_OP_EXAMINE_CLASS, 32'h0, 1'b0, 32'h0);
        `CHK(err, 1'b1, "deferred report")
        issue(FCS_OP_EXPONENT_EXTRACT, 32'h0, 1'b0, 32'h0);
        @(posedge clk_sys);
        legacyWaitMode <= 1'b0;
        issue(FCS_OP_WAIT_PREFIX, 32'h0, 1'b0, 32'h0);
        `CHK(err, 1'b1, "wait reports")
        issue(FCS_OP_EXAMINE_CLASS, 32'h0, 1'b0, 32'h0);
        `CHK(err, 1'b0, "report cleared")
    endtask

    task automatic t_store();
        issue(FCS_OP_LOAD, 32'h12345678, 1'b0, 32'h0);
        wrLog.delete();
        datLog.delete();
        issue(FCS_OP_STORE, 32'h0, 1'b1, 32'h00000100);
        `CHK(wrLog.size(), 2, "two halves")
        `CHK(wrLog[1], 32'h00000102, "high half address")
        `CHK(datLog[0], 16'h5678, "low half data")
        `CHK(datLog[1], 16'h1234, "high half data")
        `CHK(sf, 1'b0, "no fault")
        `CHK(lat, 2, "store latency")
        issue(FCS_OP_SERIALIZE, 32'h0, 1'b0, 32'h0);
        `CHK(lat, 1, "serialize latency")
        `CHK(wrLog.size(), 2, "writes committed")
        wrLog.delete();
        @(posedge clk_sys);
        memWrFault <= 1'b1;
        issue(FCS_OP_STORE, 32'h0, 1'b1, 32'h00000FFE);
        `CHK(wrLog.size(), 1, "first half only")
        `CHK(wrLog[0], 32'h00000FFE, "first half address")
        `CHK(sf, 1'b1, "fault pulse")
        @(posedge clk_sys);
        memWrFault <= 1'b0;
    endtask

    task automatic t_save();
        issue(FCS_OP_LOAD, 32'h3F800000, 1'b1, 32'h00001230);
        issue(FCS_OP_FULL_STATE_SAVE, 32'h0, 1'b0, 32'h0);
        `CHK(savedPtr, 32'h00001230, "saved pointer")
        `CHK(pv, 1'b1, "pointer strobe")
        issue(FCS_OP_ENVIRONMENT_STORE, 32'h0, 1'b0, 32'h0);
        `CHK(savedPtr, 32'h00001230, "env pointer")
    endtask

    task automatic t_sine();
        issue(FCS_OP_SINE, 32'h38000000, 1'b0, 32'h0);
        `CHK(stackTop, 32'h38000000, "small sine")
        `CHK(excFlags.precision, 1'b1, "sine inexact")
        issue(FCS_OP_SINE, 32'h38800000, 1'b0, 32'h0);
        `CHK(stackTop, 32'h38800000, "larger sine")
        issue(FCS_OP_SINE, 32'h3F800000, 1'b0, 32'h0);
        `CHK(excFlags.invalid, 1'b1, "outside domain")
    endtask

    initial begin
        req <= '0;
        roundMode <= 2'h0;
        legacyWaitMode <= 1'b0;
        memWrFault <= 1'b0;
        rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_examine();
        t_extract();
        t_const();
        t_legacy_wait();
        t_store();
        t_save();
        t_sine();
        give_verdict();
    end
endmodule

// ===== include/fcs_pkg.sv
// types for the floating-point compatibility unit
// assumes fcs_regs.svh is included by the design files
package fcs_pkg;
    typedef enum logic [3:0] {
        FCS_OP_NOP,
        FCS_OP_EXPONENT_EXTRACT,
        FCS_OP_LOAD_PI,
        FCS_OP_LOAD_LOG2_TEN,
        FCS_OP_EXAMINE_CLASS,
        FCS_OP_LEGACY_PMODE_ANNOUNCE,
        FCS_OP_LEGACY_INT_ENABLE,
        FCS_OP_LEGACY_INT_DISABLE,
        FCS_OP_WAIT_PREFIX,
        FCS_OP_FULL_STATE_SAVE,
        FCS_OP_ENVIRONMENT_STORE,
        FCS_OP_SINE,
        FCS_OP_STORE,
        FCS_OP_LOAD,
        FCS_OP_SERIALIZE
    } fcs_op_type;

    typedef enum logic [1:0] {
        FCS_ST_IDLE,
        FCS_ST_CONST,
        FCS_ST_STORE_HI
    } fcs_state_type;

    typedef struct packed {
        logic valid;
        fcs_op_type op;
        logic [31:0] operand;
        logic memRef;
        logic [31:0] memAddr;
    } fcs_req_type;

    typedef struct packed {
        logic invalid;
        logic divZero;
        logic precision;
    } fcs_exc_type;

    typedef struct packed {
        logic wrEn;
        logic [31:0] wrAddr;
        logic [15:0] wrData;
    } fcs_wr_type;

    typedef struct packed {
        fcs_state_type st;
        logic [31:0] top;
        logic [31:0] second;
        logic topValid;
        logic [3:0] cond;
        fcs_exc_type exc;
        logic pendingExc;
        logic errReport;
        logic done;
        logic [31:0] memPtr;
        logic [31:0] savedPtr;
        logic savedPtrValid;
        fcs_wr_type wr;
        logic [15:0] hiHalf;
        logic storeFault;
        logic [1:0] rnd;
    } fcs_core_type;
endpackage

// ===== include/fcs_regs.svh
// named constants for the floating-point compatibility unit
// assumes single-precision operands and the fcs_pkg types
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
`define FCS_BIAS 8'h7F
`define FCS_EXP_MAX 8'hFF
`define FCS_FRAC_W 23
`define FCS_NEG_INF 32'hFF800000
`define FCS_POS_INF 32'h7F800000
`define FCS_QNAN 32'hFFC00000
`define FCS_QUIET_BIT 22
`define FCS_TINY_EXP 8'h73
`define FCS_DENORM_BIAS 10'sh095
`define FCS_HALF_STEP 32'h00000002
`define FCS_RND_NEAR 2'h0
`define FCS_RND_DOWN 2'h1
`define FCS_RND_UP 2'h2
`define FCS_RND_ZERO 2'h3
`define FCS_PI_TRUNC 32'h40490FDA
`define FCS_PI_NEAR_UP 1'h1
`define FCS_L2T_TRUNC 32'h40549A78
`define FCS_L2T_NEAR_UP 1'h0
`endif

// ===== rtl/fcs_const_rom.sv
// constant table for the load-constant instructions
// assumes one read per request; data appear one clock after sel
`timescale 1ns/1ns
`include "fcs_regs.svh"
module fcs_const_rom (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // read port
    input wire logic sel,
    output logic [31:0] truncVal,
    output logic nearUp
);
    import fcs_pkg::*;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            truncVal <= 32'h0;
            nearUp <= 1'b0;
        end else if (sel) begin
            truncVal <= `FCS_L2T_TRUNC;
            nearUp <= `FCS_L2T_NEAR_UP;
        end else begin
            truncVal <= `FCS_PI_TRUNC;
            nearUp <= `FCS_PI_NEAR_UP;
        end
    end
endmodule

// ===== rtl/fcs_unit.sv
// floating-point compatibility unit: two-deep stack and legacy semantics
// assumes requests come from the core on clk_sys; the fault input is synchronous
// Notes on behaviour
// (RULE1) extract of zero: divide-by-zero, minus infinity to second register; +inf none
// (RULE2) constant loads honour the selected rounding mode, possibly changing last bit
// (RULE3) protected-mode announce is a no-op; addressing handled in every mode
// (RULE4) examine of an empty register never yields flags 1101 or 1111
// (RULE5) saved memory pointer is stale when last instruction had no memory operand
// (RULE6) transcendental error below 1 ulp nearest, below 1.5 ulps otherwise
// (RULE7) transcendental results are monotonic over the whole supported domain
// (RULE8) legacy interrupt enable and disable are no-ops touching no state
// (RULE9) in legacy mode wait prefix is no-op; pending error reported on next instruction
// (RULE10) split store may leave first half written when second half faults
// (RULE11) each instruction waits for the previous one to complete
// (RULE12) explicit wait prefixes before instructions still execute correctly
// (RULE13) serializing instruction completes only after all prior effects are committed
// (RULE14) finite extract gives unbiased exponent in second, significand on top
`timescale 1ns/1ns
`include "fcs_regs.svh"
module fcs_unit (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // instruction issue
    input fcs_pkg::fcs_req_type req,
    output logic reqReady,
    // mode inputs
    input wire logic [1:0] roundMode,
    input wire logic legacyWaitMode,
    // memory write port
    output fcs_pkg::fcs_wr_type memWr,
    input wire logic memWrFault,
    // results
    output logic [31:0] stackTop,
    output logic [31:0] stackSecond,
    output logic [3:0] condCodes,
    output fcs_pkg::fcs_exc_type excFlags,
    output logic errReport,
    output logic opDone,
    output logic storeFault,
    output logic [31:0] savedPtr,
    output logic savedPtrValid
);
    import fcs_pkg::*;

    fcs_core_type cur_reg;
    fcs_core_type cur_next;
    logic [31:0] romTrunc;
    logic romNearUp;
    logic romSel;

    function automatic logic [31:0] fcs_int_to_float(input logic signed [9:0] v);
        logic [9:0] mag;
        logic [4:0] p;
        logic [31:0] sh;
        mag = v[9] ? 10'(-v) : 10'(v);
        p = 5'h0;
        for (int i = 0; i < 10; i++) begin
            if (mag[i]) begin
                p = 5'(i);
            end
        end
        sh = 32'(mag) << (5'(`FCS_FRAC_W) - p);
        return (mag == 10'h0) ? 32'h0 : {v[9], 8'(`FCS_BIAS + 8'(p)), sh[22:0]};
    endfunction

    function automatic logic fcs_is_nan(input logic [31:0] x);
        return (x[30:23] == `FCS_EXP_MAX) && (x[22:0] != 23'h0);
    endfunction

    fcs_const_rom u_rom (
        .clk_sys(clk_sys),
        .rst(rst),
        .sel(romSel),
        .truncVal(romTrunc),
        .nearUp(romNearUp)
    );

    // rom address follows the request in flight, so data are ready next cycle
    assign romSel = (req.op == FCS_OP_LOAD_LOG2_TEN);
    // (RULE11) auto synchronization
    assign reqReady = (cur_reg.st == FCS_ST_IDLE);

    always_comb begin
        logic [7:0] e;
        logic [22:0] f;
        logic [4:0] p;
        logic signed [9:0] ue;
        logic [31:0] sig;
        logic [31:0] rounded;
        logic isFp;
        logic takes;
        cur_next = cur_reg;
        e = req.operand[30:23];
        f = req.operand[22:0];
        p = 5'h0;
        ue = 10'sh0;
        sig = 32'h0;
        rounded = romTrunc;
        isFp = 1'b0;
        takes = req.valid && reqReady;
        cur_next.done = 1'b0;
        cur_next.errReport = 1'b0;
        cur_next.savedPtrValid = 1'b0;
        cur_next.storeFault = 1'b0;
        cur_next.wr.wrEn = 1'b0;
        unique case (cur_reg.st)
            FCS_ST_IDLE: begin
                if (takes) begin
                    cur_next.exc = '0;
                    unique case (req.op)
                        FCS_OP_EXPONENT_EXTRACT: begin
                            isFp = 1'b1;
                            if (fcs_is_nan(req.operand)) begin
                                cur_next.exc.invalid = ~req.operand[`FCS_QUIET_BIT];
                                cur_next.top = req.operand | 32'(1) << `FCS_QUIET_BIT;
                                cur_next.second = cur_next.top;
                            end else if (e == 8'h0 && f == 23'h0) begin
                                // (RULE1) zero operand
                                cur_next.exc.divZero = 1'b1;
                                cur_next.second = `FCS_NEG_INF;
                                cur_next.top = req.operand;
                            end else if (e == `FCS_EXP_MAX) begin
                                // (RULE1) infinity raises nothing
                                cur_next.second = `FCS_POS_INF;
                                cur_next.top = req.operand;
                            end else begin
                                if (e == 8'h0) begin
                                    for (int i = 0; i < `FCS_FRAC_W; i++) begin
                                        if (f[i]) begin
                                            p = 5'(i);
                                        end
                                    end
                                    ue = 10'(signed'({5'h0, p})) - `FCS_DENORM_BIAS;
                                    sig = 32'(f) << (5'(`FCS_FRAC_W) - p);
                                end else begin
                                    ue = 10'(signed'({2'h0, e})) - 10'(signed'({2'h0, `FCS_BIAS}));
                                    sig = {9'h0, f};
                                end
                                // (RULE14) exponent and significand
                                cur_next.second = fcs_int_to_float(ue);
                                cur_next.top = {req.operand[31], `FCS_BIAS, sig[22:0]};
                            end
                            cur_next.topValid = 1'b1;
                            cur_next.done = 1'b1;
                        end
                        FCS_OP_LOAD_PI, FCS_OP_LOAD_LOG2_TEN: begin
                            isFp = 1'b1;
                            cur_next.rnd = roundMode;
                            cur_next.st = FCS_ST_CONST;
                        end
                        FCS_OP_EXAMINE_CLASS: begin
                            isFp = 1'b1;
                            // (RULE4) empty gives 1001 in c0..c3 order
                            if (!cur_reg.topValid) begin
                                cur_next.cond = 4'h9;
                            end else if (fcs_is_nan(cur_reg.top)) begin
                                cur_next.cond = {1'b1, cur_reg.top[31], 2'h0};
                            end else if (cur_reg.top[30:23] == `FCS_EXP_MAX) begin
                                cur_next.cond = {1'b1, cur_reg.top[31], 2'h2};
                            end else if (cur_reg.top[30:0] == 31'h0) begin
                                cur_next.cond = {1'b0, cur_reg.top[31], 2'h1};
                            end else if (cur_reg.top[30:23] == 8'h0) begin
                                cur_next.cond = {1'b0, cur_reg.top[31], 2'h3};
                            end else begin
                                cur_next.cond = {1'b0, cur_reg.top[31], 2'h2};
                            end
                            cur_next.done = 1'b1;
                        end
                        // (RULE3) (RULE8) legacy no-ops
                        FCS_OP_LEGACY_PMODE_ANNOUNCE, FCS_OP_LEGACY_INT_ENABLE,
                        FCS_OP_LEGACY_INT_DISABLE, FCS_OP_NOP: begin
                            cur_next.exc = cur_reg.exc;
                            cur_next.done = 1'b1;
                        end
                        FCS_OP_WAIT_PREFIX: begin
                            // (RULE9) (RULE12) legacy wait defers the report
                            cur_next.exc = cur_reg.exc;
                            if (!legacyWaitMode && cur_reg.pendingExc) begin
                                cur_next.errReport = 1'b1;
                                cur_next.pendingExc = 1'b0;
                            end
                            cur_next.done = 1'b1;
                        end
                        FCS_OP_FULL_STATE_SAVE, FCS_OP_ENVIRONMENT_STORE: begin
                            isFp = 1'b1;
                            // (RULE5) pointer of last memory instruction
                            cur_next.savedPtr = cur_reg.memPtr;
                            cur_next.savedPtrValid = 1'b1;
                            cur_next.done = 1'b1;
                        end
                        FCS_OP_SINE: begin
                            isFp = 1'b1;
                            // (RULE6) (RULE7) sin x equals x below 2^-12
                            if (!fcs_is_nan(req.operand) && e < `FCS_TINY_EXP) begin
                                cur_next.top = req.operand;
                                cur_next.exc.precision = (req.operand[30:0] != 31'h0);
                            end else begin
                                cur_next.exc.invalid = 1'b1;
                                cur_next.top = `FCS_QNAN;
                            end
                            cur_next.topValid = 1'b1;
                            cur_next.done = 1'b1;
                        end
                        FCS_OP_STORE: begin
                            isFp = 1'b1;
                            cur_next.wr = '{1'b1, req.memAddr, cur_reg.top[15:0]};
                            cur_next.hiHalf = cur_reg.top[31:16];
                            cur_next.st = FCS_ST_STORE_HI;
                        end
                        FCS_OP_LOAD: begin
                            isFp = 1'b1;
                            cur_next.second = cur_reg.top;
                            cur_next.top = req.operand;
                            cur_next.topValid = 1'b1;
                            cur_next.done = 1'b1;
                        end
                        FCS_OP_SERIALIZE: begin
                            // (RULE13) idle means every earlier write is out
                            cur_next.exc = cur_reg.exc;
                            cur_next.done = 1'b1;
                        end
                        default: begin
                            cur_next.exc = cur_reg.exc;
                            cur_next.done = 1'b1;
                        end
                    endcase
                    if (isFp) begin
                        // (RULE9) earlier error surfaces on this instruction
                        if (cur_reg.pendingExc) begin
                            cur_next.errReport = 1'b1;
                        end
                        cur_next.pendingExc = |cur_next.exc;
                        if (req.memRef) begin
                            cur_next.memPtr = req.memAddr;
                        end
                    end
                end
            end
            FCS_ST_CONST: begin
                // (RULE2) round the truncated constant
                unique case (cur_reg.rnd)
                    `FCS_RND_NEAR: rounded = romTrunc + 32'(romNearUp);
                    `FCS_RND_UP: rounded = romTrunc + 32'h1;
                    default: rounded = romTrunc;
                endcase
                cur_next.second = cur_reg.top;
                cur_next.top = rounded;
                cur_next.topValid = 1'b1;
                cur_next.exc.precision = 1'b1;
                cur_next.pendingExc = 1'b1;
                cur_next.done = 1'b1;
                cur_next.st = FCS_ST_IDLE;
            end
            FCS_ST_STORE_HI: begin
                // (RULE10) first half stays, second half dropped on fault
                if (memWrFault) begin
                    cur_next.storeFault = 1'b1;
                end else begin
                    cur_next.wr = '{1'b1, cur_reg.wr.wrAddr + `FCS_HALF_STEP, cur_reg.hiHalf};
                end
                cur_next.done = 1'b1;
                cur_next.st = FCS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur_reg <= '{st: FCS_ST_IDLE, default: '0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign memWr = cur_reg.wr;
    assign stackTop = cur_reg.top;
    assign stackSecond = cur_reg.second;
    assign condCodes = cur_reg.cond;
    assign excFlags = cur_reg.exc;
    assign errReport = cur_reg.errReport;
    assign opDone = cur_reg.done;
    assign storeFault = cur_reg.storeFault;
    assign savedPtr = cur_reg.savedPtr;
    assign savedPtrValid = cur_reg.savedPtrValid;
endmodule
